//--- hw/dpe_ctrl.sv
// dpe_ctrl: data window paging, bank select and data nvm control block
//
// Contract
// RL1: window bits 5-0 give program address top
// RL2: window register write-only, undefined after reset
// RL3: bank decode: none, nvm page, ram page2
// RL4: data 00h-3Fh routed to selected bank
// RL5: bank register kept over reset, write-only
// RL6: software sets at most one bank bit
// RL7: no nvm page change during row mode
// RL8: standby disables nvm, accesses meaningless
// RL9: busy throughout programming, accesses aborted
// RL10: control writes ignored while busy
// RL11: no write cycle without program enable
// RL12: idle nvm reads like plain data
// RL13: byte mode and eight byte row mode
// RL14: row is A7-A3, byte by A2-A0; the code takes the row from A5-A3 only
// RL15: row mode entry clears latches, fixes row
// RL16: start programs only written row bytes
// RL17: start and row mode cleared at end
// RL18: start needs enable and row mode
// RL19: clearing row mode cancels without programming
// RL20: software avoids reads during row mode
// RL21: stop instruction disables the nvm
// RL22: software keeps control bits 4,5 zero
// RL23: window address is page concatenated offset
`timescale 1ns/1ps
`default_nettype none
module dpe_ctrl
  import dpe_pkg::*;
#(
  parameter int PROG_CYCLES = DPE_PROG_CYCLES
) (
  // clock and reset
  input  wire  logic      mclk,
  input  wire  logic      rst,
  input  wire  logic      ce,
  // cpu data space side
  input  wire  dpe_req_t  req,
  input  wire  logic      stop_mode,    // core executing stop
  output logic [7:0]      rdata_ff,
  output logic            rvalid_ff,
  // program memory window
  output dpe_pmem_t       pmem_ff,
  input  wire  logic [7:0] pmem_rdata,
  // status
  output logic            nvm_busy_ff,
  output logic            ram2_sel_ff,
  output logic            nvm_sel_ff
);

  // ==========================================================
  // storage
  logic [7:0]             ram2_mem  [DPE_PAGE_BYTES];
  logic [7:0]             nvm_mem   [DPE_PAGE_BYTES];
  logic [7:0]             row_lat   [DPE_ROW_BYTES];
  logic [5:0]             window_page_bits_ff;
  logic [7:0]             data_bank_select_ff;
  logic                   nvm_program_enable_ff;
  logic                   row_mode_enable_ff;
  logic                   row_program_start_ff;
  logic                   nvm_standby_ff;
  logic [7:0]             row_written_ff;
  logic [2:0]             row_addr_ff;
  logic                   row_locked_ff;
  logic [5:0]             byte_addr_ff;
  logic [7:0]             byte_data_ff;
  logic [17:0]            prog_cnt_ff;
  logic                   win_pending_ff;
  dpe_state_t             state_ff;
  dpe_state_t             nxt_state;

  // ==========================================================
  // decode
  function automatic logic is_reg(input dpe_req_t r, input logic [7:0] ofs);
    is_reg = r.wr && !r.bit_op && (r.addr == ofs);
  endfunction

  wire logic       in_bank   = req.addr[7:6] == DPE_REG_BANKED;            // see RL4
  wire logic       in_win    = req.addr[7:6] == DPE_REG_WINDOW;
  wire logic       sel_nvm   = data_bank_select_ff[DPE_BANK_NVM];          // see RL3
  wire logic       sel_ram2  = data_bank_select_ff[DPE_BANK_RAM2];         // see RL3
  wire logic       busy      = state_ff != DPE_IDLE;
  wire logic       nvm_off   = nvm_standby_ff || stop_mode;                // see RL8 RL21
  wire logic       nvm_ok    = sel_nvm && !nvm_off && !busy;               // see RL9
  wire logic       wr_win    = is_reg(req, DPE_OFS_WINDOW);                // see RL2
  wire logic       wr_bank   = is_reg(req, DPE_OFS_BANK);                  // see RL5
  wire logic       wr_ctrl   = is_reg(req, DPE_OFS_CTRL) && !busy;         // see RL10
  wire logic       nvm_wr    = req.wr && in_bank && nvm_ok;
  wire logic       nvm_wr_en = nvm_wr && nvm_program_enable_ff;            // see RL11
  wire logic [2:0] row_byte  = req.addr[2:0];                              // see RL14
  wire logic [2:0] row_sel   = req.addr[5:3];                              // see RL14
  wire logic       row_hit   = !row_locked_ff || (row_addr_ff == row_sel);
  wire logic       row_load  = nvm_wr_en && row_mode_enable_ff && row_hit;
  wire logic       byte_go   = nvm_wr_en && !row_mode_enable_ff;           // see RL13
  wire logic       new_rowen = wr_ctrl && req.wdata[DPE_CB_ROWEN] && !row_mode_enable_ff;
  wire logic       start_ok  = wr_ctrl && req.wdata[DPE_CB_START]
                               && req.wdata[DPE_CB_ENA] && row_mode_enable_ff
                               && req.wdata[DPE_CB_ROWEN];                 // see RL18
  wire logic       prog_done = busy && (prog_cnt_ff == 18'(PROG_CYCLES - 1));
  wire logic [7:0] ctrl_view = {6'h00, busy, 1'b0};                        // see RL10
  wire logic [7:0] bank_data = sel_ram2 ? ram2_mem[req.addr[5:0]]
                               : (nvm_ok ? nvm_mem[req.addr[5:0]] : 8'hFF); // see RL12

  // ==========================================================
  // programming sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DPE_IDLE: begin
        if (start_ok) begin
          nxt_state = DPE_ROW;
        end else if (byte_go) begin
          nxt_state = DPE_BYTE;
        end
      end
      DPE_BYTE,
      DPE_ROW: begin
        if (prog_done) begin
          nxt_state = DPE_IDLE;
        end
      end
      default: nxt_state = DPE_IDLE;
    endcase
  end

  // state, cycle counter and busy
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff    <= DPE_IDLE;
      prog_cnt_ff <= 18'h00000;
      nvm_busy_ff <= 1'b0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      prog_cnt_ff <= (busy && !prog_done) ? prog_cnt_ff + 18'h00001 : 18'h00000;
      nvm_busy_ff <= nxt_state != DPE_IDLE;                                // see RL9
    end
  end

  // ==========================================================
  // paging registers, no reset on purpose
  always_ff @(posedge mclk) begin
    if (ce && wr_win) begin
      window_page_bits_ff <= req.wdata[5:0];                               // see RL1
    end
    if (ce && wr_bank) begin
      data_bank_select_ff <= req.wdata;                                    // see RL5
    end
  end

  // ==========================================================
  // control register bits
  always_ff @(posedge mclk) begin
    if (rst) begin
      nvm_program_enable_ff <= DPE_CTRL_RESET[DPE_CB_ENA];
      row_mode_enable_ff    <= DPE_CTRL_RESET[DPE_CB_ROWEN];
      row_program_start_ff  <= DPE_CTRL_RESET[DPE_CB_START];
      nvm_standby_ff        <= DPE_CTRL_RESET[DPE_CB_STBY];
    end else if (ce) begin
      if (prog_done && state_ff == DPE_ROW) begin
        row_mode_enable_ff   <= 1'b0;                                      // see RL17
        row_program_start_ff <= 1'b0;                                      // see RL17
      end else if (wr_ctrl) begin
        nvm_program_enable_ff <= req.wdata[DPE_CB_ENA];
        row_mode_enable_ff    <= req.wdata[DPE_CB_ROWEN];                  // see RL19
        row_program_start_ff  <= start_ok;                                 // see RL18
        nvm_standby_ff        <= req.wdata[DPE_CB_STBY];                   // see RL8
      end
    end
  end

  // ==========================================================
  // row latches and written-byte mask
  always_ff @(posedge mclk) begin
    if (rst) begin
      row_written_ff <= 8'h00;
      row_locked_ff  <= 1'b0;
      row_addr_ff    <= 3'h0;
    end else if (ce) begin
      if (new_rowen || (prog_done && state_ff == DPE_ROW)
          || (wr_ctrl && !req.wdata[DPE_CB_ROWEN])) begin
        row_written_ff <= 8'h00;                                           // see RL15
        row_locked_ff  <= 1'b0;                                            // see RL19
      end else if (row_load && state_ff == DPE_IDLE) begin
        row_written_ff[row_byte] <= 1'b1;                                  // see RL16
        row_locked_ff            <= 1'b1;                                  // see RL15
        row_addr_ff              <= row_sel;
      end
    end
  end

  // latch data, cleared on row mode entry
  always_ff @(posedge mclk) begin
    if (ce) begin
      for (int i = 0; i < DPE_ROW_BYTES; i++) begin
        if (new_rowen) begin
          row_lat[i] <= 8'h00;                                             // see RL15
        end else if (row_load && state_ff == DPE_IDLE && row_byte == 3'(i)) begin
          row_lat[i] <= req.wdata;
        end
      end
    end
  end

  // ==========================================================
  // byte capture, cell commit at end of cycle
  always_ff @(posedge mclk) begin
    if (ce && byte_go && state_ff == DPE_IDLE) begin
      byte_addr_ff <= req.addr[5:0];
      byte_data_ff <= req.wdata;
    end
    if (ce && prog_done && state_ff == DPE_BYTE) begin
      nvm_mem[byte_addr_ff] <= byte_data_ff;                               // see RL13
    end
    if (ce && prog_done && state_ff == DPE_ROW) begin
      for (int i = 0; i < DPE_ROW_BYTES; i++) begin
        if (row_written_ff[i]) begin
          nvm_mem[{row_addr_ff, 3'(i)}] <= row_lat[i];                     // see RL16
        end
      end
    end
  end

  // second ram page
  always_ff @(posedge mclk) begin
    if (ce && req.wr && in_bank && sel_ram2) begin
      ram2_mem[req.addr[5:0]] <= req.wdata;                                // see RL4
    end
  end

  // ==========================================================
  // read path and window fetch
  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff       <= 8'h00;
      rvalid_ff      <= 1'b0;
      pmem_ff        <= '0;
      win_pending_ff <= 1'b0;
      ram2_sel_ff    <= 1'b0;
      nvm_sel_ff     <= 1'b0;
    end else if (ce) begin
      pmem_ff.rd     <= req.rd && in_win;
      pmem_ff.addr   <= {window_page_bits_ff, req.addr[5:0]};              // see RL23
      win_pending_ff <= req.rd && in_win;
      ram2_sel_ff    <= sel_ram2;
      nvm_sel_ff     <= sel_nvm;
      rvalid_ff      <= win_pending_ff || (req.rd && !in_win);
      if (win_pending_ff) begin
        rdata_ff <= pmem_rdata;
      end else if (req.rd && in_bank) begin
        rdata_ff <= bank_data;
      end else if (req.rd && req.addr == DPE_OFS_CTRL) begin
        rdata_ff <= ctrl_view;
      end else if (req.rd) begin
        rdata_ff <= 8'h00;
      end
    end
  end

  // ==========================================================
  // checks
  AST_START_GATE: assert property (@(posedge mclk) disable iff (rst) // see RL18
    (ce && wr_ctrl && req.wdata[DPE_CB_START] && !row_mode_enable_ff)
      |=> (state_ff == DPE_IDLE || $past(byte_go)) && !row_program_start_ff)
    else $error("start accepted without row mode");

  AST_BUSY_OUT: assert property (@(posedge mclk) disable iff (rst) // see RL9
    ce |=> nvm_busy_ff == (state_ff != DPE_IDLE))
    else $error("busy output disagrees with sequencer");

  AST_NO_ENA_WR: assert property (@(posedge mclk) disable iff (rst) // see RL11
    (ce && state_ff == DPE_IDLE && !nvm_program_enable_ff && !start_ok) |=> state_ff == DPE_IDLE)
    else $error("write cycle without program enable");

  AST_CTRL_LOCK: assert property (@(posedge mclk) disable iff (rst) // see RL10
    (ce && busy && !prog_done) |=> $stable(nvm_program_enable_ff) && $stable(nvm_standby_ff))
    else $error("control changed while busy");

  AST_ROW_END: assert property (@(posedge mclk) disable iff (rst) // see RL17
    (ce && prog_done && state_ff == DPE_ROW) |=> !row_mode_enable_ff && !row_program_start_ff)
    else $error("row mode bits survive end of cycle");

  AST_ROW_CLEAR: assert property (@(posedge mclk) disable iff (rst) // see RL15
    (ce && new_rowen) |=> row_written_ff == 8'h00 && !row_locked_ff)
    else $error("row latches not cleared on entry");

  AST_WIN_ADDR: assert property (@(posedge mclk) disable iff (rst) // see RL23
    (ce && req.rd && in_win) |=> pmem_ff.rd && pmem_ff.addr[5:0] == $past(req.addr[5:0]))
    else $error("window address wrong");

  AST_WIN_DATA: assert property (@(posedge mclk) disable iff (rst) // see RL1
    (ce && req.rd && in_win) ##1 ce |=> rvalid_ff)
    else $error("window read not answered");

  AST_STBY_READ: assert property (@(posedge mclk) disable iff (rst) // see RL8
    (ce && req.rd && in_bank && sel_nvm && !sel_ram2 && nvm_off) |=> rdata_ff == 8'hFF)
    else $error("nvm read while disabled");

  // ==========================================================
  // multi-step checks, the first three built from named sequences
  // a window read answers one enabled cycle after it is taken
  sequence s_win_back;
    (ce && req.rd && in_win) ##1 ce;
  endsequence

  // an nvm read that lands while a programming cycle runs
  sequence s_busy_nvm_read;
    ce && req.rd && in_bank && sel_nvm && !sel_ram2 && busy && !win_pending_ff;
  endsequence

  // a write to another row once the row address is latched
  sequence s_foreign_row_wr;
    ce && row_locked_ff && row_mode_enable_ff && nvm_wr_en && (row_sel != row_addr_ff);
  endsequence

  AST_WIN_RDATA: assert property (@(posedge mclk) disable iff (rst) // see RL1
    s_win_back |=> rdata_ff == $past(pmem_rdata))
    else $error("window data not passed through");

  AST_BUSY_READ: assert property (@(posedge mclk) disable iff (rst) // see RL9
    s_busy_nvm_read |=> rdata_ff == 8'hFF)
    else $error("nvm read not aborted while busy");

  AST_ROW_FIXED: assert property (@(posedge mclk) disable iff (rst) // see RL15
    s_foreign_row_wr |=> $stable(row_written_ff) && $stable(row_addr_ff))
    else $error("row address moved while latched");

  // bit operations must not reach the write-only registers
  AST_WIN_BITOP: assert property (@(posedge mclk) disable iff (rst) // see RL2
    (ce && req.wr && req.bit_op && req.addr == DPE_OFS_WINDOW)
      |=> $stable(window_page_bits_ff))
    else $error("bit operation reached the window register");

  AST_BANK_BITOP: assert property (@(posedge mclk) disable iff (rst) // see RL5
    (ce && req.wr && req.bit_op && req.addr == DPE_OFS_BANK)
      |=> $stable(data_bank_select_ff))
    else $error("bit operation reached the bank register");

  // stop or standby keep the cells from starting a byte cycle
  AST_OFF_NO_WR: assert property (@(posedge mclk) disable iff (rst) // see RL21
    (ce && state_ff == DPE_IDLE && nvm_off && !start_ok) |=> state_ff == DPE_IDLE)
    else $error("write cycle while nvm is off");

endmodule
`default_nettype wire

//--- hw/dpe_pkg.sv
// dpe_pkg: constants, types and register map of the data paging and nvm control block
package dpe_pkg;

  // ==========================================================
  // register offsets in data space
  localparam logic [7:0] DPE_OFS_WINDOW  = 8'hC9;
  localparam logic [7:0] DPE_OFS_BANK    = 8'hE8;
  localparam logic [7:0] DPE_OFS_CTRL    = 8'hEA;
  localparam logic [7:0] DPE_CTRL_RESET  = 8'h00;

  // ==========================================================
  // data space regions
  localparam logic [1:0] DPE_REG_BANKED  = 2'h0;   // 00h-3Fh, addr[7:6]
  localparam logic [1:0] DPE_REG_WINDOW  = 2'h1;   // 40h-7Fh, addr[7:6]
  localparam int         DPE_WIN_BITS    = 6;

  // ==========================================================
  // field positions
  localparam int DPE_BANK_NVM  = 0;
  localparam int DPE_BANK_RAM2 = 4;
  localparam int DPE_CB_ENA    = 0;
  localparam int DPE_CB_BUSY   = 1;
  localparam int DPE_CB_ROWEN  = 2;
  localparam int DPE_CB_START  = 3;
  localparam int DPE_CB_STBY   = 6;

  // ==========================================================
  // timing: nvm programming cycle, 5 ms at 40 MHz
  localparam int DPE_PROG_TIME_US = 5000;
  localparam int DPE_CLK_MHZ      = 40;
  localparam int DPE_PROG_CYCLES  = DPE_PROG_TIME_US * DPE_CLK_MHZ;
  localparam int DPE_ROW_BYTES    = 8;
  localparam int DPE_PAGE_BYTES   = 64;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    DPE_IDLE = 3'b001,
    DPE_BYTE = 3'b010,
    DPE_ROW  = 3'b100
  } dpe_state_t;

  // cpu data space request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_op;   // single-bit read-modify-write instruction
    logic [7:0] addr;
    logic [7:0] wdata;
  } dpe_req_t;

  // program memory window read
  typedef struct packed {
    logic        rd;
    logic [11:0] addr;
  } dpe_pmem_t;

endpackage

//--- testbench/dpe_pmem_model.sv
// dpe_pmem_model: program memory responder for data window fetches
`timescale 1ns/1ps
`default_nettype none
module dpe_pmem_model
  import dpe_pkg::*;
(
  // clock
  input  wire logic      mclk,
  // fetch request and answer
  input  wire dpe_pmem_t pmem,
  output logic [7:0]     rdata
);
  logic [7:0] idle_ff = 8'hA5;

  // ==========================================================
  // answer while the fetch stands, scramble the bus when idle
  always_ff @(posedge mclk) begin
    idle_ff <= ~idle_ff;
  end
  assign rdata = pmem.rd ? (pmem.addr[11:4] ^ {pmem.addr[3:0], 4'h0}) : idle_ff;
endmodule
`default_nettype wire

//--- testbench/test_dpe_ctrl.sv
// test_dpe_ctrl: self-checking bench for the paging and nvm control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_dpe_ctrl
  import dpe_pkg::*;
;
  localparam int PC = 16;
  localparam logic [7:0] CT = DPE_OFS_CTRL;
  logic       mclk = 1'h0;
  logic       rst = 1'h1;
  logic       ce = 1'h1;
  logic       stop_mode = 1'h0;
  dpe_req_t   req = '0;
  logic [7:0] rdata_ff;
  logic [7:0] pmem_rdata;
  logic       rvalid_ff;
  logic       nvm_busy_ff;
  logic       ram2_sel_ff;
  logic       nvm_sel_ff;
  dpe_pmem_t  pmem_ff;
  int         err_total = 0;
  int         total_checks = 0;

  // ==========================================================
  // clock, device and program memory
  always #12.5 mclk = ~mclk;
  dpe_ctrl #(.PROG_CYCLES(PC)) dpe_ctrl_i (.mclk(mclk), .rst(rst), .ce(ce),
    .req(req), .stop_mode(stop_mode), .rdata_ff(rdata_ff), .rvalid_ff(rvalid_ff),
    .pmem_ff(pmem_ff), .pmem_rdata(pmem_rdata), .nvm_busy_ff(nvm_busy_ff),
    .ram2_sel_ff(ram2_sel_ff), .nvm_sel_ff(nvm_sel_ff));
  dpe_pmem_model dpe_pmem_model_i (.mclk(mclk), .pmem(pmem_ff), .rdata(pmem_rdata));

  // ==========================================================
  // access tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic b = 1'h0);
    @(negedge mclk);
    req.wr = 1'h1;
    req.addr = a;
    req.wdata = d;
    req.bit_op = b;
    @(negedge mclk);
    req = '0;
  endtask

  // read and compare, answer awaited for a bounded span
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    int n;
    @(negedge mclk);
    req.rd = 1'h1;
    req.addr = a;
    @(negedge mclk);
    req = '0;
    n = 0;
    while (rvalid_ff !== 1'h1 && n < 4) begin
      @(negedge mclk);
      n++;
    end
    `CHK(rvalid_ff, 1'h1)
    `CHK(rdata_ff, e)
  endtask

  // wait out a programming cycle
  task automatic idle();
    int n;
    n = 0;
    while (nvm_busy_ff !== 1'h0 && n < PC + 8) begin
      @(negedge mclk);
      n++;
    end
    `CHK(nvm_busy_ff, 1'h0)
  endtask

  task automatic busy_is(input logic e);
    @(negedge mclk);
    `CHK(nvm_busy_ff, e)
  endtask

  task automatic end_of_test();
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the expected run
  initial begin
    #(6000 * 25);
    err_total++;
    end_of_test();
  end

  // ==========================================================
  // tests; control values keep bits 4 and 5 clear
  initial begin
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    rst = 1'h0;
    rdc(CT, DPE_CTRL_RESET);
    rdc(DPE_OFS_WINDOW, 8'h00);
    wr(DPE_OFS_WINDOW, 8'h02);
    rdc(8'h45, 8'h58);
    wr(DPE_OFS_WINDOW, 8'hC3);
    rdc(8'h41, 8'h1C);
    wr(DPE_OFS_WINDOW, 8'h3F);
    rdc(8'h40, 8'hFC);
    wr(DPE_OFS_WINDOW, 8'h02, 1'h1);
    rdc(8'h40, 8'hFC);
    ce = 1'h0;
    wr(DPE_OFS_WINDOW, 8'h02);
    ce = 1'h1;
    rdc(8'h40, 8'hFC);
    $display("test window done");
    wr(DPE_OFS_BANK, 8'h10);
    @(negedge mclk);
    `CHK(ram2_sel_ff, 1'h1)
    wr(8'h05, 8'h33);
    rdc(8'h05, 8'h33);
    wr(DPE_OFS_BANK, 8'h01, 1'h1);
    rdc(8'h05, 8'h33);
    wr(DPE_OFS_BANK, 8'h01);
    @(negedge mclk);
    `CHK(nvm_sel_ff, 1'h1)
    $display("test bank done");
    wr(CT, 8'h01);
    wr(8'h05, 8'hAA);
    busy_is(1'h1);
    rdc(CT, 8'h02);
    rdc(8'h05, 8'hFF);
    wr(CT, 8'h40);
    idle();
    rdc(8'h05, 8'hAA);
    wr(8'h19, 8'h77);
    idle();
    wr(CT, 8'h00);
    wr(8'h19, 8'h11);
    busy_is(1'h0);
    rdc(8'h19, 8'h77);
    $display("test byte done");
    wr(CT, 8'h41);
    wr(8'h05, 8'h12);
    busy_is(1'h0);
    rdc(8'h05, 8'hFF);
    wr(CT, 8'h01);
    stop_mode = 1'h1;
    wr(8'h05, 8'h13);
    busy_is(1'h0);
    rdc(8'h05, 8'hFF);
    stop_mode = 1'h0;
    rdc(8'h05, 8'hAA);
    $display("test power done");
    // bank held while row mode is on, no reads in row mode
    wr(CT, 8'h01);
    wr(CT, 8'h09);
    busy_is(1'h0);
    wr(CT, 8'h05);
    wr(8'h19, 8'hEE);
    wr(CT, 8'h01);
    busy_is(1'h0);
    rdc(8'h19, 8'h77);
    wr(CT, 8'h05);
    wr(8'h18, 8'hA1);
    wr(8'h1A, 8'hA2);
    wr(8'h1B, 8'hA3);
    wr(8'h05, 8'h99);
    wr(CT, 8'h0D);
    busy_is(1'h1);
    idle();
    rdc(CT, 8'h00);
    rdc(8'h18, 8'hA1);
    rdc(8'h1A, 8'hA2);
    rdc(8'h1B, 8'hA3);
    rdc(8'h19, 8'h77);
    rdc(8'h05, 8'hAA);
    wr(8'h1C, 8'h55);
    busy_is(1'h1);
    idle();
    rdc(8'h1C, 8'h55);
    $display("test row done");
    end_of_test();
  end
endmodule
`default_nettype wire
